// >>> hw/sll_pkg.sv
`default_nettype none
package sll_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_STRAP = 6'h10;
    localparam logic [5:0] REG_CONFIG = 6'h12;
    localparam logic [5:0] REG_LEDCFG = 6'h13;
    localparam logic [5:0] REG_LEDSEL = 6'h1a;
    localparam logic [5:0] REG_TEST = 6'h1c;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 6;

    localparam int CTRL_AN_BIT = 12;
    localparam int ST_AN_BIT = 15;
    localparam int ST_DUP_BIT = 14;
    localparam int ST_MULTI_BIT = 5;
    localparam int CFG_ADDR_LSB = 0;
    localparam int ADDR_W = 5;
    localparam int LEDCFG_RED_BIT = 5;
    localparam int LEDSEL_4IN1_BIT = 0;
    localparam int TEST_MODE_LSB = 0;
    localparam int TEST_MODE_W = 3;
    localparam int TEST_TRIG_BIT = 3;
    localparam logic [2:0] TEST_MODE_1 = 3'h1;
    localparam logic [2:0] TEST_MODE_4 = 3'h4;
    localparam logic [2:0] TEST_MODE_OFF = 3'h0;

    localparam int CLK_MHZ = 250;
    localparam int SD_HOLD_US = 500;
    localparam int SD_HOLD_CYC = SD_HOLD_US * CLK_MHZ;
    localparam int FLASH_HALF_MS = 50;
    localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_MHZ * 1000;

    // byte-lane aware update of one register bit
    function automatic logic wr_bit(input logic old, input logic [31:0] d,
                                    input logic [3:0] sel, input int idx);
        logic [1:0] lane;
        lane = 2'(idx / 8);
        return sel[lane] ? d[idx] : old;
    endfunction
endpackage
`default_nettype wire

// >>> hw/sll_strap_if.sv
`default_nettype none
interface sll_strap_if;
    logic duplex_full;
    logic autoneg;
    logic multi_node;
    logic [sll_pkg::ADDR_W-1:0] mgmt_base_address;

    modport src (output duplex_full, autoneg, multi_node, mgmt_base_address);
    modport dst (input duplex_full, autoneg, multi_node, mgmt_base_address);
endinterface
`default_nettype wire

// >>> hw/sll_strap_latch.sv
`default_nettype none
module sll_strap_latch (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic duplex_pin,
    input wire logic autoneg_default_pin,
    input wire logic node_priority_pin,
    input wire logic mgmt_address_pin_bit0,
    input wire logic mgmt_address_pin_bit1,
    input wire logic mgmt_address_pin_bit2,
    input wire logic mgmt_address_pin_bit3,
    input wire logic mgmt_address_pin_bit4,
    sll_strap_if.src straps
);
    typedef struct packed {
        logic duplex_full;
        logic autoneg;
        logic multi_node;
        logic [sll_pkg::ADDR_W-1:0] addr;
    } sll_strap_state_type;

    sll_strap_state_type cur_reg;
    sll_strap_state_type cur_next;

    // straps follow the pins while reset holds; no async reset on purpose
    always_comb begin
        cur_next = cur_reg;
        if (clk_en && !rst_n) begin
            cur_next.duplex_full = duplex_pin;
            cur_next.autoneg = autoneg_default_pin;
            cur_next.multi_node = node_priority_pin;
            cur_next.addr = {mgmt_address_pin_bit4, mgmt_address_pin_bit3,
                             mgmt_address_pin_bit2, mgmt_address_pin_bit1,
                             mgmt_address_pin_bit0};
        end
    end

    always_ff @(posedge clk_sys) begin
        cur_reg <= cur_next;
    end

    assign straps.duplex_full = cur_reg.duplex_full;
    assign straps.autoneg = cur_reg.autoneg;
    assign straps.multi_node = cur_reg.multi_node;
    assign straps.mgmt_base_address = cur_reg.addr;
endmodule // sll_strap_latch
`default_nettype wire

// >>> hw/sll_led_ctrl.sv
`default_nettype none
module sll_led_ctrl #(
    parameter int SD_HOLD_CYCLES = sll_pkg::SD_HOLD_CYC,
    parameter int FLASH_HALF_CYCLES = sll_pkg::FLASH_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic signal_detect,
    input wire logic train_done,
    input wire logic an_done,
    input wire logic gig_link_valid,
    input wire logic remote_rx_ok,
    input wire logic link10_good,
    input wire logic link_up,
    input wire logic full_duplex,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic reduced_en,
    input wire logic four_in_one,
    output logic fast_led,
    output logic gig_led,
    output logic duplex_led
);
    localparam int SD_W = $clog2(SD_HOLD_CYCLES + 1);
    localparam int FL_W = $clog2(FLASH_HALF_CYCLES + 1);
    localparam logic [SD_W-1:0] SD_LAST = SD_W'(SD_HOLD_CYCLES - 1);
    localparam logic [FL_W-1:0] FL_LAST = FL_W'(FLASH_HALF_CYCLES - 1);

    typedef enum logic [2:0] {
        SD_DOWN = 3'b001,
        SD_QUAL = 3'b010,
        SD_UP = 3'b100
    } sll_sd_state_type;

    typedef struct packed {
        sll_sd_state_type sd_state;
        logic [SD_W-1:0] sd_cnt;
        logic [FL_W-1:0] fl_cnt;
        logic blink;
        logic act_seen;
        logic fast;
        logic gig;
        logic duplex;
    } sll_led_state_type;

    sll_led_state_type cur_reg;
    sll_led_state_type cur_next;
    logic fast_good;
    logic gig_good;
    logic any_link;
    logic activity;

    always_comb begin
        cur_next = cur_reg;
        fast_good = 1'b0;
        gig_good = train_done && an_done && gig_link_valid
                   && remote_rx_ok;
        activity = tx_active || rx_active;
        if (clk_en) begin
            case (cur_reg.sd_state)
                SD_DOWN: begin
                    cur_next.sd_cnt = '0;
                    if (signal_detect) begin
                        cur_next.sd_state = SD_QUAL;
                    end
                end
                SD_QUAL: begin
                    // qualify for the full hold time, drop at once
                    if (!signal_detect) begin
                        cur_next.sd_state = SD_DOWN;
                    end else if (cur_reg.sd_cnt == SD_LAST) begin
                        cur_next.sd_state = SD_UP;
                    end else begin
                        cur_next.sd_cnt = cur_reg.sd_cnt + SD_W'(1);
                    end
                end
                SD_UP: begin
                    if (!signal_detect) begin
                        cur_next.sd_state = SD_DOWN;
                    end
                end
                default: begin
                    cur_next.sd_state = SD_DOWN;
                end
            endcase
            // blink clock; activity held until the next toggle, set wins
            if (cur_reg.fl_cnt == FL_LAST) begin
                cur_next.fl_cnt = '0;
                cur_next.blink = !cur_reg.blink;
                cur_next.act_seen = activity;
            end else begin
                cur_next.fl_cnt = cur_reg.fl_cnt + FL_W'(1);
                cur_next.act_seen = cur_reg.act_seen || activity;
            end
        end
        fast_good = (cur_reg.sd_state == SD_UP) && signal_detect;
        any_link = link10_good || fast_good || gig_good;
        if (clk_en) begin
            if (reduced_en) begin
                // one combined lamp on the fast link pin
                cur_next.fast = any_link;
                if (four_in_one && cur_reg.act_seen) begin
                    cur_next.fast = any_link && cur_reg.blink;
                end
                cur_next.gig = 1'b0;
            end else begin
                cur_next.fast = fast_good;
                cur_next.gig = gig_good;
            end
            cur_next.duplex = full_duplex && link_up;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur_reg <= '{sd_state: SD_DOWN, default: '0};
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign fast_led = cur_reg.fast;
    assign gig_led = cur_reg.gig;
    assign duplex_led = cur_reg.duplex;
endmodule // sll_led_ctrl
`default_nettype wire

// >>> hw/sll_strap_led.sv
// Function
// - The duplex strap caught at reset sets the default: high full duplex, low half duplex only.
// - The caught duplex strap reads back in bit 14 of strap status register 0x10.
// - The caught auto-negotiation strap reads back in bit 15 of register 0x10.
// - That strap gives only the reset value of control bit 0x00.12, which software may overwrite.
// - The fast link lamp lights after signal detect held 500 us and drops at once with it.
// - The gigabit link lamp lights only with training, negotiation, valid link and good reception.
// - Five address straps are caught at reset as the management address, pin four the MSB.
// - The caught management address reads back in bits 4:0 of configuration register 0x12.
// - The duplex lamp is lit in full duplex once a link is up, and dark otherwise.
// - The node-priority strap picks multi-node (high) or single-node (low) gigabit priority.
// - The caught node-priority strap reads back in bit 5 of register 0x10.
// - The trigger output on the node-priority pin works only in test modes 1 and 4.
// - Reduced lamp modes are chosen by bit 0x13.5 and bit 0x1A.0.
// - Three-in-one merges all good-link lamps into one; four-in-one adds activity too.
// - In four-in-one mode the lamp is steady for link and flashes on traffic; three-in-one stays steady.
`default_nettype none
module sll_strap_led #(
    parameter int SD_HOLD_CYCLES = sll_pkg::SD_HOLD_CYC,
    parameter int FLASH_HALF_CYCLES = sll_pkg::FLASH_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic fast_link_indicator_level,
    output logic fast_link_indicator_drive,
    output logic fast_link_indicator_oe,
    input wire logic gigabit_link_indicator_level,
    output logic gigabit_link_indicator_drive,
    output logic gigabit_link_indicator_oe,
    input wire logic mgmt_address_pin_bit0_level,
    output logic duplex_indicator_drive,
    output logic duplex_indicator_oe,
    input wire logic mgmt_address_pin_bit1,
    input wire logic mgmt_address_pin_bit2,
    input wire logic mgmt_address_pin_bit3,
    input wire logic mgmt_address_pin_bit4,
    input wire logic node_priority_level,
    output logic tx_trigger_drive,
    output logic tx_trigger_oe,
    input wire logic signal_detect,
    input wire logic train_done,
    input wire logic an_done,
    input wire logic gig_link_valid,
    input wire logic remote_rx_ok,
    input wire logic link10_good,
    input wire logic link_up,
    input wire logic full_duplex,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic tx_trigger_source,
    output logic autoneg_enable,
    output logic full_duplex_default,
    output logic advertise_multi_node,
    output logic [sll_pkg::ADDR_W-1:0] mgmt_base_address
);
    typedef struct packed {
        logic [1:0] rst_sync;
        logic pins_on;
        logic an_en;
        logic reduced_en;
        logic four_in_one;
        logic [sll_pkg::TEST_MODE_W-1:0] test_mode;
        logic trig_en;
        logic trig;
        logic ack;
        logic [31:0] rdata;
    } sll_top_state_type;

    sll_top_state_type cur_reg;
    sll_top_state_type cur_next;
    logic rst_n_sync;
    logic req;
    logic [sll_pkg::IDX_W-1:0] idx;
    logic [31:0] rd_word;
    logic fast_led;
    logic gig_led;
    logic duplex_led;

    sll_strap_if straps ();

    assign rst_n_sync = cur_reg.rst_sync[1];
    assign idx = wb_adr[sll_pkg::IDX_LSB +: sll_pkg::IDX_W];
    assign req = wb_cyc && wb_stb && !cur_reg.ack;

    sll_strap_latch u_straps (
        .clk_sys(clk_sys),
        .rst_n(rst_n_sync),
        .clk_en(clk_en),
        .duplex_pin(fast_link_indicator_level),
        .autoneg_default_pin(gigabit_link_indicator_level),
        .node_priority_pin(node_priority_level),
        .mgmt_address_pin_bit0(mgmt_address_pin_bit0_level),
        .mgmt_address_pin_bit1(mgmt_address_pin_bit1),
        .mgmt_address_pin_bit2(mgmt_address_pin_bit2),
        .mgmt_address_pin_bit3(mgmt_address_pin_bit3),
        .mgmt_address_pin_bit4(mgmt_address_pin_bit4),
        .straps(straps.src)
    );

    sll_led_ctrl #(
        .SD_HOLD_CYCLES(SD_HOLD_CYCLES),
        .FLASH_HALF_CYCLES(FLASH_HALF_CYCLES)
    ) u_leds (
        .clk_sys(clk_sys),
        .rst_n(rst_n_sync),
        .clk_en(clk_en),
        .signal_detect(signal_detect),
        .train_done(train_done),
        .an_done(an_done),
        .gig_link_valid(gig_link_valid),
        .remote_rx_ok(remote_rx_ok),
        .link10_good(link10_good),
        .link_up(link_up),
        .full_duplex(full_duplex),
        .tx_active(tx_active),
        .rx_active(rx_active),
        .reduced_en(cur_reg.reduced_en),
        .four_in_one(cur_reg.four_in_one),
        .fast_led(fast_led),
        .gig_led(gig_led),
        .duplex_led(duplex_led)
    );

    // read mux; unmapped indices read as zero
    always_comb begin
        rd_word = '0;
        case (idx)
            sll_pkg::REG_CTRL: begin
                rd_word[sll_pkg::CTRL_AN_BIT] = cur_reg.an_en;
            end
            sll_pkg::REG_STRAP: begin
                rd_word[sll_pkg::ST_AN_BIT] = straps.autoneg;
                rd_word[sll_pkg::ST_DUP_BIT] = straps.duplex_full;
                rd_word[sll_pkg::ST_MULTI_BIT] = straps.multi_node;
            end
            sll_pkg::REG_CONFIG: begin
                rd_word[sll_pkg::CFG_ADDR_LSB +: sll_pkg::ADDR_W] =
                    straps.mgmt_base_address;
            end
            sll_pkg::REG_LEDCFG: begin
                rd_word[sll_pkg::LEDCFG_RED_BIT] = cur_reg.reduced_en;
            end
            sll_pkg::REG_LEDSEL: begin
                rd_word[sll_pkg::LEDSEL_4IN1_BIT] = cur_reg.four_in_one;
            end
            sll_pkg::REG_TEST: begin
                rd_word[sll_pkg::TEST_MODE_LSB +: sll_pkg::TEST_MODE_W] =
                    cur_reg.test_mode;
                rd_word[sll_pkg::TEST_TRIG_BIT] = cur_reg.trig_en;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    always_comb begin
        cur_next = cur_reg;
        cur_next.rst_sync = {cur_reg.rst_sync[0], 1'b1};
        if (clk_en) begin
            cur_next.pins_on = rst_n_sync;
            cur_next.ack = req;
            if (req) begin
                cur_next.rdata = rd_word;
            end
            if (!cur_reg.pins_on) begin
                // strap gives the reset value only
                cur_next.an_en = straps.autoneg;
                cur_next.reduced_en = 1'b0;
                cur_next.four_in_one = 1'b0;
                cur_next.test_mode = sll_pkg::TEST_MODE_OFF;
                cur_next.trig_en = 1'b0;
            end else if (wb_cyc && wb_stb && wb_we && cur_reg.ack) begin
                // writes land on the edge that sees ack
                case (idx)
                    sll_pkg::REG_CTRL: begin
                        cur_next.an_en = sll_pkg::wr_bit(cur_reg.an_en,
                            wb_dat_w, wb_sel, sll_pkg::CTRL_AN_BIT);
                    end
                    sll_pkg::REG_LEDCFG: begin
                        cur_next.reduced_en = sll_pkg::wr_bit(
                            cur_reg.reduced_en, wb_dat_w, wb_sel,
                            sll_pkg::LEDCFG_RED_BIT);
                    end
                    sll_pkg::REG_LEDSEL: begin
                        cur_next.four_in_one = sll_pkg::wr_bit(
                            cur_reg.four_in_one, wb_dat_w, wb_sel,
                            sll_pkg::LEDSEL_4IN1_BIT);
                    end
                    sll_pkg::REG_TEST: begin
                        if (wb_sel[0]) begin
                            cur_next.test_mode = wb_dat_w[
                                sll_pkg::TEST_MODE_LSB +: sll_pkg::TEST_MODE_W];
                            cur_next.trig_en =
                                wb_dat_w[sll_pkg::TEST_TRIG_BIT];
                        end
                    end
                    default: begin
                        cur_next.an_en = cur_reg.an_en;
                    end
                endcase
            end
            cur_next.trig = cur_reg.trig_en && tx_trigger_source
                && (cur_reg.test_mode == sll_pkg::TEST_MODE_1
                    || cur_reg.test_mode == sll_pkg::TEST_MODE_4);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign wb_ack = cur_reg.ack;
    assign wb_dat_r = cur_reg.rdata;
    // pins stay released until reset is over
    assign fast_link_indicator_oe = cur_reg.pins_on;
    assign gigabit_link_indicator_oe = cur_reg.pins_on;
    assign duplex_indicator_oe = cur_reg.pins_on;
    assign tx_trigger_oe = cur_reg.pins_on;
    assign fast_link_indicator_drive = fast_led;
    assign gigabit_link_indicator_drive = gig_led;
    assign duplex_indicator_drive = duplex_led;
    assign tx_trigger_drive = cur_reg.trig;
    assign autoneg_enable = cur_reg.an_en;
    assign full_duplex_default = straps.duplex_full;
    assign advertise_multi_node = straps.multi_node;
    assign mgmt_base_address = straps.mgmt_base_address;
endmodule // sll_strap_led
`default_nettype wire

// >>> verif/sll_pin_model.sv
`default_nettype none
module sll_pin_model (
    input wire logic [7:0] strap,
    input wire logic fast_link_indicator_oe,
    input wire logic fast_link_indicator_drive,
    input wire logic gigabit_link_indicator_oe,
    input wire logic gigabit_link_indicator_drive,
    input wire logic duplex_indicator_oe,
    input wire logic duplex_indicator_drive,
    input wire logic tx_trigger_oe,
    input wire logic tx_trigger_drive,
    output logic fast_link_indicator_level,
    output logic gigabit_link_indicator_level,
    output logic mgmt_address_pin_bit0_level,
    output logic node_priority_level,
    output logic mgmt_address_pin_bit1,
    output logic mgmt_address_pin_bit2,
    output logic mgmt_address_pin_bit3,
    output logic mgmt_address_pin_bit4
);
    timeunit 1ns;
    timeprecision 1ps;
    // strap resistor wins only while the pin is released
    assign fast_link_indicator_level = fast_link_indicator_oe ?
        fast_link_indicator_drive : strap[7];
    assign gigabit_link_indicator_level = gigabit_link_indicator_oe ?
        gigabit_link_indicator_drive : strap[6];
    assign node_priority_level = tx_trigger_oe ?
        tx_trigger_drive : strap[5];
    assign mgmt_address_pin_bit0_level = duplex_indicator_oe ?
        duplex_indicator_drive : strap[0];
    assign {mgmt_address_pin_bit4, mgmt_address_pin_bit3,
        mgmt_address_pin_bit2, mgmt_address_pin_bit1} = strap[4:1];
endmodule // sll_pin_model
`default_nettype wire

// >>> verif/sll_strap_led_props.sv
`default_nettype none
module sll_strap_led_props (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_ack,
    input wire logic fast_link_indicator_level,
    input wire logic fast_link_indicator_drive,
    input wire logic fast_link_indicator_oe,
    input wire logic gigabit_link_indicator_level,
    input wire logic gigabit_link_indicator_drive,
    input wire logic gigabit_link_indicator_oe,
    input wire logic mgmt_address_pin_bit0_level,
    input wire logic duplex_indicator_drive,
    input wire logic duplex_indicator_oe,
    input wire logic node_priority_level,
    input wire logic tx_trigger_drive,
    input wire logic tx_trigger_oe,
    input wire logic signal_detect,
    input wire logic train_done,
    input wire logic an_done,
    input wire logic gig_link_valid,
    input wire logic remote_rx_ok,
    input wire logic link10_good,
    input wire logic link_up,
    input wire logic full_duplex,
    input wire logic tx_trigger_source,
    input wire logic autoneg_enable,
    input wire logic full_duplex_default,
    input wire logic advertise_multi_node,
    input wire logic [sll_pkg::ADDR_W-1:0] mgmt_base_address
);
    timeunit 1ns;
    timeprecision 1ps;
    logic g;
    assign g = train_done && an_done && gig_link_valid && remote_rx_ok;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_dark;
        !fast_link_indicator_oe && !gigabit_link_indicator_oe
            && !duplex_indicator_oe && !tx_trigger_oe;
    endsequence
    sequence s_lit;
        fast_link_indicator_oe && gigabit_link_indicator_oe
            && duplex_indicator_oe && tx_trigger_oe;
    endsequence
    property p_oe_on;
        $rose(reset_n) |-> s_dark [*2] ##[1:2] s_lit;
    endproperty
    property p_strap;
        $rose(fast_link_indicator_oe) |->
            full_duplex_default == $past(fast_link_indicator_level, 2)
            && autoneg_enable == $past(gigabit_link_indicator_level, 2)
            && advertise_multi_node == $past(node_priority_level, 2)
            && mgmt_base_address[0] == $past(mgmt_address_pin_bit0_level, 2);
    endproperty
    property p_hold;
        fast_link_indicator_oe |=> fast_link_indicator_oe
            && $stable(full_duplex_default) && $stable(mgmt_base_address)
            && $stable(advertise_multi_node);
    endproperty
    property p_fast;
        (!signal_detect && !link10_good && !g) [*2]
            |=> !fast_link_indicator_drive;
    endproperty
    property p_gig;
        gigabit_link_indicator_drive |-> $past(g);
    endproperty
    property p_dup;
        duplex_indicator_oe && $past(duplex_indicator_oe) |->
            duplex_indicator_drive == $past(full_duplex && link_up);
    endproperty
    property p_trig;
        tx_trigger_drive |-> $past(tx_trigger_source);
    endproperty
    property p_ack;
        wb_cyc && wb_stb && !wb_ack |=> wb_ack ##1 !wb_ack;
    endproperty
    property p_ack_src;
        wb_ack |-> $past(wb_cyc && wb_stb);
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("pin enables wrong");
    a_strap: assert property (p_strap) else $error("strap copy wrong");
    a_hold: assert property (p_hold) else $error("strap copy moved");
    a_fast: assert property (p_fast) else $error("fast lamp stuck on");
    a_gig: assert property (p_gig) else $error("gig lamp without link");
    a_dup: assert property (p_dup) else $error("duplex lamp wrong");
    a_trig: assert property (p_trig) else $error("trigger without source");
    a_ack: assert property (p_ack) else $error("ack not one cycle");
    a_ack_src: assert property (p_ack_src) else $error("ack without request");
endmodule // sll_strap_led_props
bind sll_strap_led sll_strap_led_props u_props (.*);
`default_nettype wire

// >>> verif/tb_sll_strap_led.sv
`default_nettype none
module tb_sll_strap_led;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'h0, reset_n = 1'h0, clk_en = 1'h1;
    logic wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0, wb_ack;
    logic [7:0] wb_adr = 8'h00, strap = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0, wb_dat_r, q;
    logic signal_detect = 1'h0, train_done = 1'h0, an_done = 1'h0;
    logic gig_link_valid = 1'h0, remote_rx_ok = 1'h0, link10_good = 1'h0;
    logic link_up = 1'h0, full_duplex = 1'h0, tx_active = 1'h0;
    logic rx_active = 1'h0, tx_trigger_source = 1'h0;
    logic fast_link_indicator_level, fast_link_indicator_drive;
    logic fast_link_indicator_oe, gigabit_link_indicator_level;
    logic gigabit_link_indicator_drive, gigabit_link_indicator_oe;
    logic mgmt_address_pin_bit0_level, duplex_indicator_drive;
    logic duplex_indicator_oe, mgmt_address_pin_bit1, mgmt_address_pin_bit2;
    logic mgmt_address_pin_bit3, mgmt_address_pin_bit4, node_priority_level;
    logic tx_trigger_drive, tx_trigger_oe, autoneg_enable;
    logic full_duplex_default, advertise_multi_node;
    logic [4:0] mgmt_base_address;
    int errors = 0, cmp_count = 0, t;
    sll_strap_led #(.SD_HOLD_CYCLES(20), .FLASH_HALF_CYCLES(8)) dut (.*);
    sll_pin_model pins (.*);
    always #2 clk_sys = ~clk_sys;
    task automatic final_report();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_sys);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat_w <= d;
        wb_sel <= s;
        do begin
            @(posedge clk_sys);
        end while (wb_ack !== 1'h1);
        q = wb_dat_r;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0, 4'hf);
        chk("read data", q, e);
    endtask
    task automatic flips(input int n);
        logic p;
        t = 0;
        p = fast_link_indicator_drive;
        repeat (n) begin
            @(posedge clk_sys);
            if (fast_link_indicator_drive !== p) t++;
            p = fast_link_indicator_drive;
        end
    endtask
    task automatic strap_case(input logic [7:0] s);
        logic [31:0] st, an;
        st = {16'h0, s[6], s[7], 8'h00, s[5], 5'h00};
        an = {19'h0, s[6], 12'h000};
        @(posedge clk_sys);
        reset_n <= 1'h0;
        strap <= s;
        cyc(12);
        reset_n <= 1'h1;
        cyc(5);
        chk("duplex default", full_duplex_default, s[7]);
        chk("autoneg enable", autoneg_enable, s[6]);
        chk("multi node", advertise_multi_node, s[5]);
        chk("mgmt address", mgmt_base_address, s[4:0]);
        rd(8'h40, st);
        rd(8'h48, {27'h0, s[4:0]});
        rd(8'h00, an);
        bus(1'h1, 8'h40, ~st, 4'hf);
        rd(8'h40, st);
        bus(1'h1, 8'h00, ~an, 4'h1);
        rd(8'h00, an);
        bus(1'h1, 8'h00, ~an, 4'h2);
        rd(8'h00, ~an & 32'h1000);
        chk("autoneg enable", autoneg_enable, !s[6]);
        rd(8'h3c, 32'h0);
    endtask
    initial begin
        strap_case(8'hb6);
        strap_case(8'h49);
        for (int i = 0; i < 2; i++) begin
            signal_detect <= 1'h1;
            cyc(18);
            chk("fast lamp", fast_link_indicator_drive, 1'h0);
            signal_detect <= 1'h0;
            cyc(2);
        end
        signal_detect <= 1'h1;
        cyc(24);
        chk("fast lamp", fast_link_indicator_drive, 1'h1);
        signal_detect <= 1'h0;
        cyc(2);
        chk("fast lamp", fast_link_indicator_drive, 1'h0);
        for (int i = 0; i < 16; i++) begin
            {train_done, an_done, gig_link_valid, remote_rx_ok} <= 4'(i);
            {full_duplex, link_up} <= 2'(i);
            cyc(3);
            chk("gig lamp", gigabit_link_indicator_drive, i == 15);
            chk("duplex lamp", duplex_indicator_drive, i % 4 == 3);
        end
        bus(1'h1, 8'h4c, 32'h20, 4'h1);
        cyc(3);
        chk("combined lamp", fast_link_indicator_drive, 1'h1);
        chk("gig lamp", gigabit_link_indicator_drive, 1'h0);
        {train_done, link10_good, tx_active} <= 3'h3;
        cyc(3);
        flips(32);
        chk("steady lamp", {fast_link_indicator_drive, 8'(t)}, 9'h100);
        bus(1'h1, 8'h68, 32'h1, 4'h1);
        for (int i = 1; i < 4; i++) begin
            {rx_active, tx_active} <= 2'(i % 3);
            cyc(20);
            flips(32);
            chk("flash", t > 2, i < 3);
        end
        chk("steady lamp", fast_link_indicator_drive, 1'h1);
        link10_good <= 1'h0;
        cyc(3);
        chk("combined lamp", fast_link_indicator_drive, 1'h0);
        tx_trigger_source <= 1'h1;
        for (int m = 0; m < 17; m++) begin
            if (m == 16) tx_trigger_source <= 1'h0;
            bus(1'h1, 8'h70, 32'(m == 16 ? 9 : m), 4'h1);
            cyc(3);
            chk("trigger", tx_trigger_drive, m == 9 || m == 12);
        end
        final_report();
    end
    initial begin
        #40000;
        errors++;
        final_report();
    end
endmodule // tb_sll_strap_led
`default_nettype wire
